// ---- src/status_led_consts.svh ----
`ifndef STATUS_LED_CONSTS_SVH
`define STATUS_LED_CONSTS_SVH

// Clock rate
`define CLK_HZ             100_000_000

// Blink and watchdog timing, in milliseconds
`define FAST_HALF_MS       100
`define SLOW_PERIOD_MS     2000
`define YELLOW_LIMIT_MS    500

// Derived cycle counts
`define FAST_HALF_CYC      ((`FAST_HALF_MS * (`CLK_HZ / 1000)))
`define SLOW_HALF_CYC      (((`SLOW_PERIOD_MS / 2) * (`CLK_HZ / 1000)))
`define YELLOW_LIMIT_CYC   ((`YELLOW_LIMIT_MS * (`CLK_HZ / 1000)))

// Register byte offsets
`define REG_EVT_STATUS     4'h0
`define REG_EVT_CLEAR      4'h4
`define REG_EVT_ENABLE     4'h8
`define REG_LED_STATE      4'hC

// Event bit positions
`define EVT_HW_ERROR       0
`define EVT_BUS_ERROR      1
`define EVT_LINK_CHANGE    2
`define EVT_YELLOW_STUCK   3
`define EVT_COUNT          4

// LED state bit positions
`define LED_SYS_GREEN      0
`define LED_SYS_YELLOW     1
`define LED_COM_GREEN      2
`define LED_COM_RED        3
`define LED_LINK           4
`define LED_TRAFFIC        5

// Reset values
`define EVT_ENABLE_RST     4'h0

`endif

// ---- src/status_led_pkg.sv ----
`default_nettype none
package status_led_pkg;

  typedef enum logic [1:0] {
    SYS_DARK      = 2'b00,
    SYS_YELLOW    = 2'b01,
    SYS_ALTERNATE = 2'b10,
    SYS_GREEN     = 2'b11
  } sys_mode_e;

  typedef enum logic [2:0] {
    COM_DARK      = 3'b000,
    COM_SHARED    = 3'b001,
    COM_OWNER     = 3'b010,
    COM_BAUD      = 3'b011,
    COM_ERROR     = 3'b100
  } com_mode_e;

  typedef logic [31:0] word_t;

endpackage
`default_nettype wire

// ---- src/blink_divider.sv ----
`timescale 1ns/1ps
`default_nettype none

module blink_divider #(
  parameter int unsigned HALF_CYC = 10
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  output logic      tick_o,
  output logic      phase_o
);

  localparam int unsigned CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_r;

  // Half-period counter
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_r == LAST) begin
      cnt_r  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + CW'(1);
      tick_o <= 1'b0;
    end
  end

  // Lit phase first, then dark
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_o <= 1'b1;
    end else if (cnt_r == LAST) begin
      phase_o <= ~phase_o;
    end
  end

endmodule

`default_nettype wire

// ---- src/event_bank.sv ----
`timescale 1ns/1ps
`default_nettype none

module event_bank #(
  parameter int unsigned N = 4,
  parameter logic [N-1:0] EN_RST = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [N-1:0] event_i,
  input  wire logic         clear_wr_i,
  input  wire logic         enable_wr_i,
  input  wire logic [N-1:0] wdata_i,
  output logic      [N-1:0] status_o,
  output logic      [N-1:0] enable_o,
  output logic              irq_o
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      // Sticky bit, set beats clear
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          status_o[g] <= 1'b0;
        end else if (event_i[g]) begin
          status_o[g] <= 1'b1;
        end else if (clear_wr_i && wdata_i[g]) begin
          status_o[g] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          enable_o[g] <= EN_RST[g];
        end else if (enable_wr_i) begin
          enable_o[g] <= wdata_i[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_o & enable_o);
    end
  end

endmodule

`default_nettype wire

// ---- src/gateway_status_led_driver.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "status_led_consts.svh"

module gateway_status_led_driver #(
  parameter int unsigned FAST_HALF_CYC    = `FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF_CYC    = `SLOW_HALF_CYC,
  parameter int unsigned YELLOW_LIMIT_CYC = `YELLOW_LIMIT_CYC
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // Status conditions
  input  wire logic                 bootloader_active_i,
  input  wire logic                 firmware_started_i,
  input  wire logic                 hw_error_i,
  input  wire logic                 token_held_i,
  input  wire logic                 token_shared_i,
  input  wire logic                 autobaud_i,
  input  wire logic                 bus_error_i,
  input  wire logic                 eth_link_i,
  input  wire logic                 eth_tx_i,
  input  wire logic                 eth_rx_i,
  // Indicators
  output logic                      system_indicator_green_o,
  output logic                      system_indicator_yellow_o,
  output logic                      com_indicator_green_o,
  output logic                      com_indicator_red_o,
  output logic                      ethernet_link_indicator_o,
  output logic                      ethernet_traffic_indicator_o,
  output logic                      irq_o,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire status_led_pkg::word_t avs_writedata,
  output status_led_pkg::word_t      avs_readdata,
  output logic                      avs_waitrequest
);

  import status_led_pkg::*;

  localparam int unsigned NEVT = `EVT_COUNT;
  localparam int unsigned YW   = (YELLOW_LIMIT_CYC > 1) ? $clog2(YELLOW_LIMIT_CYC + 1) : 1;
  localparam logic [YW-1:0] YLIM = YW'(YELLOW_LIMIT_CYC);

  sys_mode_e        sys_mode_nxt;
  com_mode_e        com_mode_nxt;
  logic             fast_phase;
  logic             slow_phase;
  logic             hw_error_d_r;
  logic             bus_error_d_r;
  logic             link_d_r;
  logic [YW-1:0]    yellow_cnt_r;
  logic             yellow_stuck_r;
  logic             yellow_stuck_d_r;
  logic [NEVT-1:0]  events;
  logic [NEVT-1:0]  evt_status;
  logic [NEVT-1:0]  evt_enable;
  logic             irq_int;
  logic             access;
  logic             done;
  logic             wr_low;
  logic             clear_wr;
  logic             enable_wr;
  logic [5:0]       led_state;
  word_t            rdata_nxt;

  // 5 Hz pacing, 100 ms per half
  blink_divider #(
    .HALF_CYC (FAST_HALF_CYC)
  ) u_fast (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (),
    .phase_o   (fast_phase)
  );

  // 0.5 Hz pacing
  blink_divider #(
    .HALF_CYC (SLOW_HALF_CYC)
  ) u_slow (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (),
    .phase_o   (slow_phase)
  );

  // System mode selection
  always_comb begin
    if (hw_error_i) begin
      sys_mode_nxt = SYS_DARK;
    end else if (firmware_started_i) begin
      sys_mode_nxt = SYS_GREEN;
    end else if (bootloader_active_i) begin
      sys_mode_nxt = SYS_ALTERNATE;
    end else begin
      sys_mode_nxt = SYS_YELLOW;
    end
  end

  // System indicator drive
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_indicator_green_o  <= 1'b0;
      system_indicator_yellow_o <= 1'b0;
    end else begin
      unique case (sys_mode_nxt)
        SYS_DARK: begin
          system_indicator_green_o  <= 1'b0;
          system_indicator_yellow_o <= 1'b0;
        end
        SYS_YELLOW: begin
          system_indicator_green_o  <= 1'b0;
          system_indicator_yellow_o <= 1'b1;
        end
        SYS_ALTERNATE: begin
          system_indicator_green_o  <= fast_phase;
          system_indicator_yellow_o <= ~fast_phase;
        end
        SYS_GREEN: begin
          system_indicator_green_o  <= 1'b1;
          system_indicator_yellow_o <= 1'b0;
        end
      endcase
    end
  end

  // Communication mode, by priority
  always_comb begin
    if (bus_error_i) begin
      com_mode_nxt = COM_ERROR;
    end else if (autobaud_i) begin
      com_mode_nxt = COM_BAUD;
    end else if (token_held_i) begin
      com_mode_nxt = COM_OWNER;
    end else if (token_shared_i) begin
      com_mode_nxt = COM_SHARED;
    end else begin
      com_mode_nxt = COM_DARK;
    end
  end

  // Communication indicator drive
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      com_indicator_green_o <= 1'b0;
      com_indicator_red_o   <= 1'b0;
    end else begin
      unique case (com_mode_nxt)
        COM_ERROR: begin
          com_indicator_green_o <= 1'b0;
          com_indicator_red_o   <= 1'b1;
        end
        COM_BAUD: begin
          com_indicator_green_o <= slow_phase;
          com_indicator_red_o   <= 1'b0;
        end
        COM_OWNER: begin
          com_indicator_green_o <= 1'b1;
          com_indicator_red_o   <= 1'b0;
        end
        COM_SHARED: begin
          com_indicator_green_o <= fast_phase;
          com_indicator_red_o   <= 1'b0;
        end
        COM_DARK: begin
          com_indicator_green_o <= 1'b0;
          com_indicator_red_o   <= 1'b0;
        end
        default: begin
          com_indicator_green_o <= 1'b0;
          com_indicator_red_o   <= 1'b0;
        end
      endcase
    end
  end

  // Link indicator follows the link state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ethernet_link_indicator_o <= 1'b0;
    end else begin
      ethernet_link_indicator_o <= eth_link_i;
    end
  end

  // Traffic indicator lit on either direction
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ethernet_traffic_indicator_o <= 1'b0;
    end else begin
      ethernet_traffic_indicator_o <= eth_tx_i | eth_rx_i;
    end
  end

  // Steady yellow run length
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      yellow_cnt_r <= '0;
    end else if (sys_mode_nxt != SYS_YELLOW) begin
      yellow_cnt_r <= '0;
    end else if (yellow_cnt_r != YLIM) begin
      yellow_cnt_r <= yellow_cnt_r + YW'(1);
    end
  end

  // Stuck flag once the run reaches its limit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      yellow_stuck_r <= 1'b0;
    end else begin
      yellow_stuck_r <= (sys_mode_nxt == SYS_YELLOW) && (yellow_cnt_r == YLIM);
    end
  end

  // Error histories for rise events
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hw_error_d_r <= 1'b0;
    end else begin
      hw_error_d_r <= hw_error_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_error_d_r <= 1'b0;
    end else begin
      bus_error_d_r <= bus_error_i;
    end
  end

  // Link history for change events
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_d_r <= 1'b0;
    end else begin
      link_d_r <= eth_link_i;
    end
  end

  // Watchdog history for a one-shot event
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      yellow_stuck_d_r <= 1'b0;
    end else begin
      yellow_stuck_d_r <= yellow_stuck_r;
    end
  end

  always_comb begin
    events                    = '0;
    events[`EVT_HW_ERROR]     = hw_error_i & ~hw_error_d_r;
    events[`EVT_BUS_ERROR]    = bus_error_i & ~bus_error_d_r;
    events[`EVT_LINK_CHANGE]  = eth_link_i ^ link_d_r;
    events[`EVT_YELLOW_STUCK] = yellow_stuck_r & ~yellow_stuck_d_r;
  end

  // Bus handshake: wait one cycle, then answer
  assign access    = avs_read | avs_write;
  assign done      = access & ~avs_waitrequest;
  assign wr_low    = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign clear_wr  = wr_low && (avs_address == `REG_EVT_CLEAR);
  assign enable_wr = wr_low && (avs_address == `REG_EVT_ENABLE);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest <= 1'b1;
    end else if (done) begin
      avs_waitrequest <= 1'b1;
    end else if (access) begin
      avs_waitrequest <= 1'b0;
    end
  end

  event_bank #(
    .N      (NEVT),
    .EN_RST (`EVT_ENABLE_RST)
  ) u_events (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .event_i     (events),
    .clear_wr_i  (clear_wr),
    .enable_wr_i (enable_wr),
    .wdata_i     (avs_writedata[NEVT-1:0]),
    .status_o    (evt_status),
    .enable_o    (evt_enable),
    .irq_o       (irq_int)
  );

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_int;
    end
  end

  // Live indicator state for readback
  always_comb begin
    led_state                 = '0;
    led_state[`LED_SYS_GREEN]  = system_indicator_green_o;
    led_state[`LED_SYS_YELLOW] = system_indicator_yellow_o;
    led_state[`LED_COM_GREEN]  = com_indicator_green_o;
    led_state[`LED_COM_RED]    = com_indicator_red_o;
    led_state[`LED_LINK]       = ethernet_link_indicator_o;
    led_state[`LED_TRAFFIC]    = ethernet_traffic_indicator_o;
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rdata_nxt = '0;
    unique case (avs_address)
      `REG_EVT_STATUS: rdata_nxt[NEVT-1:0] = evt_status;
      `REG_EVT_ENABLE: rdata_nxt[NEVT-1:0] = evt_enable;
      `REG_LED_STATE:  rdata_nxt[5:0]      = led_state;
      default:         rdata_nxt           = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/status_led_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module status_led_sva #(
  parameter int unsigned FAST_HALF_CYC = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bootloader_active_i,
  input wire logic firmware_started_i,
  input wire logic hw_error_i,
  input wire logic token_held_i,
  input wire logic token_shared_i,
  input wire logic autobaud_i,
  input wire logic bus_error_i,
  input wire logic eth_link_i,
  input wire logic eth_tx_i,
  input wire logic eth_rx_i,
  input wire logic system_indicator_green_o,
  input wire logic system_indicator_yellow_o,
  input wire logic com_indicator_green_o,
  input wire logic com_indicator_red_o,
  input wire logic ethernet_link_indicator_o,
  input wire logic ethernet_traffic_indicator_o,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic        sg, sy, cg, cr, hw, fw, sh, cg_q, sh_q, lk, tf;
  logic [31:0] run_r, sc_r;
  assign sg = system_indicator_green_o;
  assign sy = system_indicator_yellow_o;
  assign cg = com_indicator_green_o;
  assign cr = com_indicator_red_o;
  assign hw = hw_error_i;
  assign fw = firmware_started_i;
  assign lk = ethernet_link_indicator_o;
  assign tf = ethernet_traffic_indicator_o;
  assign sh = token_shared_i && !token_held_i && !autobaud_i && !bus_error_i;
  // Run length of com green and span of shared mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cg_q  <= 1'b0;
      sh_q  <= 1'b0;
      run_r <= 32'h0000_0000;
      sc_r  <= 32'h0000_0000;
    end else begin
      cg_q  <= cg;
      sh_q  <= sh;
      run_r <= (cg != cg_q) ? 32'h0000_0001 : run_r + 32'h0000_0001;
      sc_r  <= sh_q ? sc_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  sequence ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sys_dark_a: assert property (hw |=> !sg && !sy)
    else $error("system indicator lit on hw error");
  sys_green_a: assert property (!hw && fw |=> sg && !sy)
    else $error("system indicator not green");
  sys_alt_a: assert property (!hw && !fw && bootloader_active_i |=> sg != sy)
    else $error("system indicator not alternating");
  sys_yellow_a: assert property (!hw && !fw && !bootloader_active_i |=> sy && !sg)
    else $error("system indicator not yellow");
  com_red_a: assert property (bus_error_i |=> cr && !cg)
    else $error("com indicator not red");
  com_owner_a: assert property (!bus_error_i && !autobaud_i && token_held_i |=>
    cg && !cr)
    else $error("com indicator not steady green");
  com_baud_a: assert property (!bus_error_i && autobaud_i |=> !cr)
    else $error("com indicator red without error");
  com_dark_a: assert property (!(bus_error_i || autobaud_i || token_held_i) &&
    !token_shared_i |=> !cg && !cr)
    else $error("com indicator lit outside ring");
  link_state_a: assert property (1'b1 |=> lk == $past(eth_link_i))
    else $error("link indicator wrong");
  traffic_a: assert property (1'b1 |=> tf == $past(eth_tx_i || eth_rx_i))
    else $error("traffic indicator wrong");
  fast_blink_a: assert property ((cg != cg_q) && sh_q && sc_r > run_r |->
    run_r == FAST_HALF_CYC)
    else $error("fast blink half period wrong");
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> ack_s)
    else $error("bus answer not one cycle");
endmodule
bind gateway_status_led_driver status_led_sva #(.FAST_HALF_CYC(FAST_HALF_CYC)) u_sva (.*);
`default_nettype wire

// ---- testbench/led_panel_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module led_panel_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        led_i,
  output logic      [15:0] on_len_o,
  output logic      [15:0] off_len_o
);
  logic        led_q;
  logic [15:0] run_r;
  // Length of the last finished lit and dark runs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_q     <= 1'b0;
      run_r     <= 16'h0000;
      on_len_o  <= 16'h0000;
      off_len_o <= 16'h0000;
    end else begin
      led_q <= led_i;
      if (led_i != led_q) begin
        run_r <= 16'h0001;
        if (led_q) on_len_o <= run_r;
        else off_len_o <= run_r;
      end else begin
        run_r <= run_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import status_led_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [9:0]  cnd;
  logic [3:0]  avs_address, avs_byteenable;
  logic [5:0]  led;
  logic [11:0] e;
  logic [15:0] c_on, c_off, s_on, s_off;
  word_t       avs_writedata, avs_readdata, rdv;
  int          num_errors = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  gateway_status_led_driver #(.FAST_HALF_CYC(10), .SLOW_HALF_CYC(100), .YELLOW_LIMIT_CYC(20)) dut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .bootloader_active_i(cnd[0]),
    .firmware_started_i(cnd[1]), .hw_error_i(cnd[2]), .token_held_i(cnd[3]),
    .token_shared_i(cnd[4]), .autobaud_i(cnd[5]), .bus_error_i(cnd[6]), .eth_link_i(cnd[7]),
    .eth_tx_i(cnd[8]), .eth_rx_i(cnd[9]), .system_indicator_green_o(led[0]),
    .system_indicator_yellow_o(led[1]), .com_indicator_green_o(led[2]),
    .com_indicator_red_o(led[3]), .ethernet_link_indicator_o(led[4]),
    .ethernet_traffic_indicator_o(led[5]), .irq_o(irq), .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest);
  led_panel_model cm (.clk_sys_i(clk), .rst_n_i(rst_n), .led_i(led[2]), .on_len_o(c_on),
    .off_len_o(c_off));
  led_panel_model sm (.clk_sys_i(clk), .rst_n_i(rst_n), .led_i(led[0]), .on_len_o(s_on),
    .off_len_o(s_off));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input word_t d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic settle(input logic [9:0] c, input int n);
    @(posedge clk);
    cnd <= c;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Mask and value of the steady indicator bits
  function automatic logic [11:0] exp_led(input logic [9:0] c);
    logic [5:0] v;
    logic [5:0] m;
    v = 6'h00;
    m = 6'h3f;
    if (!c[2]) begin
      if (c[1]) v[0] = 1'b1;
      else if (c[0]) m[1:0] = 2'h0;
      else v[1] = 1'b1;
    end
    if (c[6]) v[3] = 1'b1;
    else if (c[5]) m[2] = 1'b0;
    else if (c[3]) v[2] = 1'b1;
    else if (c[4]) m[2] = 1'b0;
    v[4] = c[7];
    v[5] = c[8] | c[9];
    return {m, v};
  endfunction
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100_000;
    num_errors++;
    close_out;
  end
  initial begin
    cnd = 10'h000;
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_byteenable = 4'hf;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    void'($urandom(1920));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(rdv, 32'h0000_0000, "enable reset value");
    repeat (300) begin
      settle(10'($urandom), 1);
      e = exp_led(cnd);
      chk(32'(led[1:0] & e[7:6]), 32'(e[1:0] & e[7:6]), "sys");
      chk(32'(led[3:2] & e[9:8]), 32'(e[3:2] & e[9:8]), "com");
      chk(32'(led[5:4]), 32'(e[5:4]), "ethernet");
      if (cnd[2:0] == 3'h1) chk(32'(led[0] ^ led[1]), 32'h0000_0001, "alternate");
    end
    $display("random test done");
    settle(10'h011, 60);
    chk(32'(c_on), 32'h0000_000a, "shared lit");
    chk(32'(c_off), 32'h0000_000a, "shared dark");
    chk(32'(s_on), 32'h0000_000a, "alternate green");
    chk(32'(s_off), 32'h0000_000a, "alternate yellow");
    $display("fast blink test done");
    settle(10'h03a, 450);
    chk(32'(c_on), 32'h0000_0064, "baud lit");
    chk(32'(c_off), 32'h0000_0064, "baud dark");
    chk(32'(led[1:0]), 32'h0000_0001, "firmware green");
    $display("slow blink test done");
    settle(10'h002, 3);
    bus(1'b1, 4'h4, 32'h0000_000f);
    bus(1'b1, 4'h8, 32'h0000_0002);
    settle(10'h042, 3);
    chk(32'(irq), 32'h0000_0001, "irq raised");
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rdv, 32'h0000_0002, "status bus error");
    avs_byteenable <= 4'he;
    bus(1'b1, 4'h8, 32'h0000_0000);
    avs_byteenable <= 4'hf;
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk(rdv, 32'h0000_0002, "byteenable ignored");
    bus(1'b0, 4'hc, 32'h0000_0000);
    chk(rdv, 32'h0000_0009, "led state register");
    bus(1'b1, 4'h8, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'h0000_0000, "irq masked");
    bus(1'b1, 4'h4, 32'h0000_0002);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rdv, 32'h0000_0000, "status cleared");
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(rdv, 32'h0000_0000, "unmapped read");
    settle(10'h000, 30);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rdv, 32'h0000_0008, "yellow stuck event");
    $display("register test done");
    close_out;
  end
endmodule
`default_nettype wire
